// ---- common/uor_pkg.sv ----
package uor_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int UOR_AW = 10;
  localparam int UOR_DW = 8;
  localparam logic [UOR_AW-1:0] UOR_OFS_RUN = 10'h2e0;
  localparam logic [UOR_AW-1:0] UOR_OFS_INTERP = 10'h2e1;
  localparam logic [UOR_AW-1:0] UOR_OFS_GAIN = 10'h2e2;
  localparam logic [UOR_AW-1:0] UOR_OFS_FORMAT = 10'h2e3;
  localparam logic [UOR_AW-1:0] UOR_OFS_ROUTE = 10'h2e4;
  localparam logic [UOR_AW-1:0] UOR_OFS_PULSE = 10'h2e8;
  localparam logic [UOR_AW-1:0] UOR_OFS_STATUS = 10'h2ef;
  localparam logic [UOR_DW-1:0] UOR_RST_REG = 8'h00;
  localparam logic [UOR_DW-1:0] UOR_RD_NONE = 8'h00;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int UOR_RUN_BIT = 0;
  localparam int UOR_COMPLEX_BIT = 0;
  localparam int UOR_INTERP_LSB = 0;
  localparam int UOR_ROUTE_A_LSB = 0;
  localparam int UOR_ROUTE_B_LSB = 4;
  localparam int UOR_PULSE_A_LSB = 0;
  localparam int UOR_PULSE_B_LSB = 4;
  localparam int UOR_ST_RUN_BIT = 0;
  localparam int UOR_ST_MIX_BIT = 1;
  localparam int UOR_ST_RSV_BIT = 2;

  // interpolation code 0 is factor one: up-converters bypassed
  localparam logic [3:0] UOR_INTERP_1X = 4'h0;
  localparam logic [3:0] UOR_ALLOW_REAL = 4'hf;
  localparam logic [3:0] UOR_ALLOW_CPLX = 4'h3;
  localparam logic [3:0] UOR_SEL_IMAG = 4'hc;
  localparam logic [3:0] UOR_SEL_REAL = 4'h3;

  localparam logic [1:0] UOR_GAIN_0DB = 2'h0;
  localparam logic [1:0] UOR_GAIN_6DB = 2'h1;
  localparam logic [1:0] UOR_GAIN_12DB = 2'h2;

  localparam int UOR_SW = 16;

  typedef enum logic [2:0] {
    UOR_PF_NRZ = 3'h0,
    UOR_PF_RTI = 3'h1,
    UOR_PF_RTZ = 3'h2,
    UOR_PF_DRLP = 3'h3,
    UOR_PF_DRHP = 3'h4,
    UOR_PF_RSV5 = 3'h5,
    UOR_PF_OFF = 3'h6,
    UOR_PF_RSV7 = 3'h7
  } uor_pulse_t;

  typedef struct packed {
    logic [UOR_SW-1:0] in_i;
    logic [UOR_SW-1:0] in_q;
    logic [3:0][UOR_SW-1:0] re;
    logic [1:0][UOR_SW-1:0] im;
  } uor_samp_t;

  typedef struct packed {
    logic enable;
    logic nrz;
    logic rti;
    logic rtz;
    logic dr_lp;
    logic dr_hp;
  } uor_conv_t;

  localparam uor_conv_t UOR_CONV_IDLE = '0;

  function automatic logic [UOR_SW-1:0] uor_gain(
    input logic [UOR_SW-1:0] s,
    input logic [1:0] g
  );
    logic [UOR_SW-1:0] r;
    case (g)
      UOR_GAIN_6DB: r = $signed(s) >>> 1;
      UOR_GAIN_12DB: r = $signed(s) >>> 2;
      default: r = s;
    endcase
    return r;
  endfunction : uor_gain

  // reserved codes leave the converter off: safest output
  function automatic uor_conv_t uor_decode_pulse(input logic [2:0] m);
    uor_conv_t c;
    c = UOR_CONV_IDLE;
    case (uor_pulse_t'(m))
      UOR_PF_NRZ: c.nrz = 1'b1;
      UOR_PF_RTI: c.rti = 1'b1;
      UOR_PF_RTZ: c.rtz = 1'b1;
      UOR_PF_DRLP: c.dr_lp = 1'b1;
      UOR_PF_DRHP: c.dr_hp = 1'b1;
      default: c.nrz = 1'b0;
    endcase
    c.enable = c.nrz | c.rti | c.rtz | c.dr_lp | c.dr_hp;
    return c;
  endfunction : uor_decode_pulse

endpackage : uor_pkg

// ---- design/uor_sum.sv ----
`timescale 1ns/10ps
module uor_sum import uor_pkg::*; #(
  parameter int SW = UOR_SW
) (
  input wire logic [3:0] sel,
  input wire logic bypass,
  input wire logic complex_fmt,
  input wire logic [3:0][1:0] gain,
  input wire uor_samp_t samp,
  output logic [SW-1:0] sum
);

  localparam logic signed [SW+1:0] MAXV = {3'b000, {(SW-1){1'b1}}};
  localparam logic signed [SW+1:0] MINV = {3'b111, {(SW-1){1'b0}}};

  wire [SW-1:0] term [4];
  logic signed [SW+1:0] ext [4];
  logic signed [SW+1:0] acc;

  // bypass feeds raw streams; otherwise gain-scaled up-converter outputs
  assign term[0] = bypass ? samp.in_i : uor_gain(samp.re[0], gain[0]);
  assign term[1] = bypass ? samp.in_q : uor_gain(samp.re[1], gain[1]);
  // complex format: gains 2 and 3 scale the imaginary parts
  assign term[2] = complex_fmt ? uor_gain(samp.im[0], gain[2])
                               : uor_gain(samp.re[2], gain[2]);
  assign term[3] = complex_fmt ? uor_gain(samp.im[1], gain[3])
                               : uor_gain(samp.re[3], gain[3]);

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_term
      // upper select bits do nothing in bypass
      wire use_term = sel[k] && !(bypass && k >= 2);
      assign ext[k] = use_term ? {{2{term[k][SW-1]}}, term[k]} : '0;
    end
  endgenerate

  // several selected terms add up, saturating at full scale
  always_comb begin
    acc = '0;
    for (int j = 0; j < 4; j++) begin
      acc = acc + ext[j];
    end
  end

  assign sum = (acc > MAXV) ? MAXV[SW-1:0] :
               (acc < MINV) ? MINV[SW-1:0] : acc[SW-1:0];

endmodule : uor_sum

// ---- design/uor_top.sv ----
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps

// Functional notes
// - format bit clear: mixers output real only; four up-converters allowed.
// - format bit set: complex outputs; only up-converters 0 and 1 allowed.
// - interpolation at most one: routing field picks raw input streams.
// - bypass: bit 0 picks stream I, bit 1 stream Q; bits 2, 3 ignored.
// - interpolation two or more: routing bits pick up-converter outputs.
// - bits 0,1 real of 0,1; bits 2,3 real of 2,3 or imag of 0,1.
// - several set bits are summed before the converter.
// - pulse register bits 6..4 set converter B pulse format.
// - pulse register bits 2..0 set converter A; bits 7 and 3 reserved.
// - code 0 NRZ, 1 return-to-inverse, 2 return-to-zero.
// - code 3 double-rate low-pass, 4 high-pass, 6 off, 7 reserved.
// - datapath run bit clear holds the datapath in reset.
// - complex format: gains 2, 3 scale imaginary outputs of 0, 1.
module uor_top import uor_pkg::*; #(
  parameter int SW = UOR_SW
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [UOR_AW-1:0] REG_ADDR,
  input wire logic [UOR_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [UOR_DW-1:0] REG_RDATA,
  input wire uor_samp_t SAMPLES,
  input wire logic SAMPLE_VALID,
  output logic [SW-1:0] CONV_A_DATA,
  output logic [SW-1:0] CONV_B_DATA,
  output logic CONV_VALID,
  output uor_conv_t CONV_A_CTL,
  output uor_conv_t CONV_B_CTL,
  output logic UC_COMPLEX,
  output logic [3:0] UC_ALLOW,
  output logic DATAPATH_RUN
);

  // ********************************************************
  // registers
  // ********************************************************
  logic run;
  logic [3:0] interp;
  logic [3:0][1:0] gain;
  logic complex_fmt;
  logic [7:0] route;
  logic [2:0] pulse_a;
  logic [2:0] pulse_b;

  wire wr_run = REG_WR && (REG_ADDR == UOR_OFS_RUN);
  wire wr_interp = REG_WR && (REG_ADDR == UOR_OFS_INTERP);
  wire wr_gain = REG_WR && (REG_ADDR == UOR_OFS_GAIN);
  wire wr_format = REG_WR && (REG_ADDR == UOR_OFS_FORMAT);
  wire wr_route = REG_WR && (REG_ADDR == UOR_OFS_ROUTE);
  wire wr_pulse = REG_WR && (REG_ADDR == UOR_OFS_PULSE);

  // writes while running are taken as-is; glitches are the user's
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      run <= 1'b0;
      interp <= '0;
      gain <= '0;
    end else begin
      if (wr_run) run <= REG_WDATA[UOR_RUN_BIT];
      if (wr_interp) interp <= REG_WDATA[UOR_INTERP_LSB +: 4];
      if (wr_gain) gain <= REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      complex_fmt <= 1'b0;
      route <= UOR_RST_REG;
      pulse_a <= UOR_PF_NRZ;
      pulse_b <= UOR_PF_NRZ;
    end else begin
      if (wr_format) complex_fmt <= REG_WDATA[UOR_COMPLEX_BIT];
      if (wr_route) route <= REG_WDATA;
      // bits 7 and 3 are not stored
      if (wr_pulse) pulse_a <= REG_WDATA[UOR_PULSE_A_LSB +: 3];
      if (wr_pulse) pulse_b <= REG_WDATA[UOR_PULSE_B_LSB +: 3];
    end
  end

  // ********************************************************
  // status and read-back
  // ********************************************************
  wire [3:0] route_a = route[UOR_ROUTE_A_LSB +: 4];
  wire [3:0] route_b = route[UOR_ROUTE_B_LSB +: 4];
  wire bypass = (interp == UOR_INTERP_1X);

  function automatic logic bad_route(input logic [3:0] r,
                                     input logic byp,
                                     input logic cpx);
    logic both;
    both = r[0] && r[1];
    if (byp) return both;
    return cpx && |(r & UOR_SEL_REAL) && |(r & UOR_SEL_IMAG);
  endfunction : bad_route

  // flags only; the sum is still formed so behaviour stays defined
  wire mix_flag = bad_route(route_a, bypass, complex_fmt) ||
                  bad_route(route_b, bypass, complex_fmt);
  wire rsv_flag = (pulse_a == UOR_PF_RSV5) || (pulse_b == UOR_PF_RSV5) ||
                  (pulse_a == UOR_PF_RSV7) || (pulse_b == UOR_PF_RSV7);

  wire [7:0] status = {5'h00, rsv_flag, mix_flag, run};
  wire [7:0] pulse_rd = {1'b0, pulse_b, 1'b0, pulse_a};

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = UOR_RD_NONE;
    if (REG_RD) begin
      case (REG_ADDR)
        UOR_OFS_RUN: next_rdata = {7'h00, run};
        UOR_OFS_INTERP: next_rdata = {4'h0, interp};
        UOR_OFS_GAIN: next_rdata = gain;
        UOR_OFS_FORMAT: next_rdata = {7'h00, complex_fmt};
        UOR_OFS_ROUTE: next_rdata = route;
        UOR_OFS_PULSE: next_rdata = pulse_rd;
        UOR_OFS_STATUS: next_rdata = status;
        default: next_rdata = UOR_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) REG_RDATA <= UOR_RD_NONE;
    else REG_RDATA <= next_rdata;
  end

  // ********************************************************
  // datapath, held in reset while stopped
  // ********************************************************
  wire dp_rst = SYS_RST || !run;
  wire [SW-1:0] sum_a;
  wire [SW-1:0] sum_b;

  uor_sum #(.SW(SW)) u_sum_a (
    .sel(route_a),
    .bypass(bypass),
    .complex_fmt(complex_fmt),
    .gain(gain),
    .samp(SAMPLES),
    .sum(sum_a)
  );

  uor_sum #(.SW(SW)) u_sum_b (
    .sel(route_b),
    .bypass(bypass),
    .complex_fmt(complex_fmt),
    .gain(gain),
    .samp(SAMPLES),
    .sum(sum_b)
  );

  wire uor_conv_t dec_a = uor_decode_pulse(pulse_a);
  wire uor_conv_t dec_b = uor_decode_pulse(pulse_b);
  // a disabled converter gets silence rather than stale samples
  wire [SW-1:0] out_a = dec_a.enable ? sum_a : '0;
  wire [SW-1:0] out_b = dec_b.enable ? sum_b : '0;
  wire [3:0] allow = complex_fmt ? UOR_ALLOW_CPLX
                                 : UOR_ALLOW_REAL;

  always_ff @(posedge CORE_CLK) begin
    if (dp_rst) begin
      CONV_A_DATA <= '0;
      CONV_B_DATA <= '0;
      CONV_VALID <= 1'b0;
      CONV_A_CTL <= UOR_CONV_IDLE;
      CONV_B_CTL <= UOR_CONV_IDLE;
      UC_COMPLEX <= 1'b0;
      UC_ALLOW <= '0;
    end else begin
      CONV_A_DATA <= out_a;
      CONV_B_DATA <= out_b;
      CONV_VALID <= SAMPLE_VALID;
      CONV_A_CTL <= dec_a;
      CONV_B_CTL <= dec_b;
      UC_COMPLEX <= complex_fmt;
      UC_ALLOW <= allow;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) DATAPATH_RUN <= 1'b0;
    else DATAPATH_RUN <= run;
  end

  // ********************************************************
  // assertions
  // ********************************************************
  wire gains_flat = (gain == '0);

  AST_REAL_FMT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && !complex_fmt |=> !UC_COMPLEX && UC_ALLOW == 4'hf)
    else $error("real format not presented to mixers");

  AST_CPLX_FMT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && complex_fmt |=> UC_COMPLEX && UC_ALLOW == 4'h3)
    else $error("complex format allows wrong up-converters");

  AST_BYP_I: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && bypass && route_a[1:0] == 2'b01 && dec_a.enable
    |=> CONV_A_DATA == $past(SAMPLES.in_i))
    else $error("bypass stream I not routed to converter A");

  AST_BYP_Q: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && bypass && route_b[1:0] == 2'b10 && dec_b.enable
    |=> CONV_B_DATA == $past(SAMPLES.in_q))
    else $error("bypass stream Q wrong or upper bits used");

  AST_DUC_REAL: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && !bypass && !complex_fmt && route_a == 4'h4 && gains_flat &&
    dec_a.enable |=> CONV_A_DATA == $past(SAMPLES.re[2]))
    else $error("real up-converter 2 not routed");

  AST_DUC_SUM: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && !bypass && route_b == 4'h3 && gains_flat && dec_b.enable &&
    SAMPLES.re[0] == 16'h0100 && SAMPLES.re[1] == 16'h0200
    |=> CONV_B_DATA == 16'h0300)
    else $error("selected outputs not summed");

  AST_GAIN_IM: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && !bypass && complex_fmt && route_a == 4'h4 &&
    gain[2] == UOR_GAIN_6DB && dec_a.enable
    |=> $signed(CONV_A_DATA) ==
        ($signed($past(SAMPLES.im[0])) >>> 1))
    else $error("imaginary gain not applied");

  AST_PF_B: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && pulse_b == UOR_PF_RTI
    |=> CONV_B_CTL.rti && CONV_B_CTL.enable)
    else $error("converter B pulse field not applied");

  AST_PF_A_OFF: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && pulse_a == 3'h6 |=> !CONV_A_CTL.enable && CONV_A_DATA == '0)
    else $error("converter A not disabled by code 6");

  AST_DRATE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && pulse_b == 3'h3 |=> CONV_B_CTL.dr_lp && !CONV_B_CTL.dr_hp)
    else $error("double-rate low-pass not selected");

  AST_DP_RESET: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !run |=> !CONV_VALID && CONV_A_DATA == '0 && !UC_COMPLEX)
    else $error("datapath not held in reset while stopped");

  AST_READ: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    REG_RD && REG_ADDR == UOR_OFS_ROUTE |=> REG_RDATA == $past(route))
    else $error("routing register read-back wrong");

  AST_RD_IDLE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !REG_RD |=> REG_RDATA == UOR_RD_NONE)
    else $error("read data not idle between reads");

  AST_ST_RUN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    REG_RD && REG_ADDR == UOR_OFS_STATUS
    |=> REG_RDATA[UOR_ST_RUN_BIT] == $past(run))
    else $error("status run bit wrong");

  AST_VALID: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run |=> CONV_VALID == $past(SAMPLE_VALID))
    else $error("converter valid does not follow samples");

  AST_RUN_FLAG: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    1'b1 |=> DATAPATH_RUN == $past(run))
    else $error("datapath run flag wrong");

  AST_RSV_A: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && (pulse_a == UOR_PF_RSV5 || pulse_a == UOR_PF_RSV7)
    |=> !CONV_A_CTL.enable && CONV_A_DATA == '0)
    else $error("reserved code left converter A on");

  AST_PF_B_OFF: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && pulse_b == UOR_PF_OFF
    |=> !CONV_B_CTL.enable && CONV_B_DATA == '0)
    else $error("converter B not disabled by its own field");

  AST_PF_A_NRZ: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && pulse_a == UOR_PF_NRZ
    |=> CONV_A_CTL.nrz && CONV_A_CTL.enable)
    else $error("converter A not in non-return-to-zero");

  COV_BYPASS: cover property (@(posedge CORE_CLK)
    run && bypass && route_a == 4'h1 && CONV_VALID);
  COV_CPLX_SUM: cover property (@(posedge CORE_CLK)
    run && complex_fmt && route_b[3]);
  COV_OFF: cover property (@(posedge CORE_CLK)
    run && pulse_b == 3'h6);
  COV_STOP: cover property (@(posedge CORE_CLK)
    DATAPATH_RUN ##1 !DATAPATH_RUN);

endmodule : uor_top

// ---- sim/uor_dac_model.sv ----
`timescale 1ns/10ps
module uor_dac_model import uor_pkg::*; #(
  parameter int SW = UOR_SW
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SW-1:0] data,
  input wire logic valid,
  input wire uor_conv_t ctl,
  output logic [SW-1:0] last
);
  // a disabled core ignores its input, as the real one does
  always_ff @(posedge clk) begin
    if (rst) begin
      last <= '0;
    end else if (valid && ctl.enable) begin
      last <= data;
    end
  end
endmodule : uor_dac_model

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench import uor_pkg::*; ();
  logic clk;
  logic rst;
  logic [UOR_AW-1:0] addr;
  logic [UOR_DW-1:0] wdata;
  logic wr;
  logic rd;
  logic [UOR_DW-1:0] rdata;
  uor_samp_t samp;
  logic svalid;
  logic [UOR_SW-1:0] a_data;
  logic [UOR_SW-1:0] b_data;
  logic cvalid;
  uor_conv_t a_ctl;
  uor_conv_t b_ctl;
  logic cplx;
  logic [3:0] allow;
  logic run;
  logic [UOR_SW-1:0] a_last;
  logic [UOR_SW-1:0] b_last;
  int failures;
  int comparisons;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};

  uor_top #(.SW(UOR_SW)) DUT (.CORE_CLK(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .SAMPLES(samp), .SAMPLE_VALID(svalid),
    .CONV_A_DATA(a_data), .CONV_B_DATA(b_data), .CONV_VALID(cvalid),
    .CONV_A_CTL(a_ctl), .CONV_B_CTL(b_ctl), .UC_COMPLEX(cplx),
    .UC_ALLOW(allow), .DATAPATH_RUN(run));

  uor_dac_model #(.SW(UOR_SW)) conv_a_model (.clk(clk), .rst(rst),
    .data(a_data), .valid(cvalid), .ctl(a_ctl), .last(a_last));

  uor_dac_model #(.SW(UOR_SW)) conv_b_model (.clk(clk), .rst(rst),
    .data(b_data), .valid(cvalid), .ctl(b_ctl), .last(b_last));

  // ****
  // bus and check tasks
  // ****
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [UOR_AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [UOR_AW-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check($sformatf("register %h", a), {8'h00, exp}, {8'h00, rdata});
  endtask : reg_rd

  // stop, configure, restart, then let three samples pass
  task automatic cfg(input logic [7:0] fmt, input logic [7:0] lt,
                     input logic [7:0] gain, input logic [7:0] route,
                     input logic [7:0] pulse);
    reg_wr(UOR_OFS_RUN, 8'h00);
    reg_wr(UOR_OFS_FORMAT, fmt);
    reg_wr(UOR_OFS_INTERP, lt);
    reg_wr(UOR_OFS_GAIN, gain);
    reg_wr(UOR_OFS_ROUTE, route);
    reg_wr(UOR_OFS_PULSE, pulse);
    reg_wr(UOR_OFS_RUN, 8'h01);
    repeat (3) @(posedge clk);
    #1;
  endtask : cfg

  function automatic logic [5:0] exp_ctl(input logic [2:0] m);
    return (m < 3'h5) ? {1'b1, 5'h10 >> m} : 6'h00;
  endfunction : exp_ctl

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ****
  // clock, watchdog, sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #2000000;
    failures++;
    $display("unexpected run length: expected end, seen timeout");
    finish_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    svalid = 1'b0;
    failures = 0;
    comparisons = 0;
    // re0..3 = 100..400, im0 negative to expose a logical shift
    samp = {16'h0123, 16'h0456, 16'h0400, 16'h0300, 16'h0200, 16'h0100,
            16'h0a00, 16'hf000};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    svalid <= 1'b1;
    reg_rd(UOR_OFS_FORMAT, 8'h00);
    reg_rd(UOR_OFS_ROUTE, 8'h00);
    reg_rd(UOR_OFS_PULSE, 8'h00);
    check("stopped valid", 16'h0, {15'h0, cvalid});
    check("stopped data", 16'h0, a_data);
    check("stopped allow", 16'h0, {12'h0, allow});
    reg_rd(UOR_OFS_STATUS, 8'h00);
    reg_wr(UOR_OFS_PULSE, 8'hff);
    reg_rd(UOR_OFS_PULSE, 8'h77);
    reg_wr(UOR_OFS_FORMAT, 8'hff);
    reg_rd(UOR_OFS_FORMAT, 8'h01);
    reg_wr(UOR_OFS_ROUTE, 8'ha5);
    reg_rd(UOR_OFS_ROUTE, 8'ha5);
    reg_wr(10'h3ff, 8'hff);
    reg_rd(10'h3ff, 8'h00);
    // bypass: A has bits 0,2,3 set, the upper two must be ignored
    cfg(8'h00, 8'h00, 8'h00, 8'h2d, 8'h00);
    check("bypass A", 16'h0123, a_data);
    check("bypass B", 16'h0456, b_data);
    check("running valid", 16'h1, {15'h0, cvalid});
    check("running flag", 16'h1, {15'h0, run});
    check("core A input", 16'h0123, a_last);
    check("core B input", 16'h0456, b_last);
    reg_rd(UOR_OFS_STATUS, 8'h01);
    // real format, A = re0 + re2 at -6 dB, B = re1 + re3
    cfg(8'h00, 8'h01, 8'h10, 8'ha5, 8'h00);
    check("real A", 16'h0280, a_data);
    check("real B", 16'h0600, b_data);
    check("real allow", 16'h000f, {12'h0, allow});
    check("real fmt", 16'h0, {15'h0, cplx});
    reg_rd(UOR_OFS_INTERP, 8'h01);
    reg_rd(UOR_OFS_GAIN, 8'h10);
    // samples marked invalid while running
    @(posedge clk);
    svalid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("idle valid", 16'h0, {15'h0, cvalid});
    @(posedge clk);
    svalid <= 1'b1;
    // real format, flat gains: A = re2 alone, B = re0 + re1
    cfg(8'h00, 8'h01, 8'h00, 8'h34, 8'h00);
    check("real re2 A", 16'h0300, a_data);
    check("real sum B", 16'h0300, b_data);
    // complex format, imaginary outputs scaled by gains 2 and 3
    cfg(8'h01, 8'h01, 8'h50, 8'h84, 8'h00);
    check("imag A", 16'hf800, a_data);
    check("imag B", 16'h0500, b_data);
    check("cplx allow", 16'h0003, {12'h0, allow});
    check("cplx fmt", 16'h1, {15'h0, cplx});
    // code 5 is never programmed by software
    for (int i = 0; i < 7; i++) begin
      cfg(8'h01, 8'h01, 8'h50, 8'h84,
          {1'b0, codes[(i + 3) % 7], 1'b0, codes[i]});
      check("ctl A", {10'h0, exp_ctl(codes[i])}, {10'h0, a_ctl});
      check("ctl B", {10'h0, exp_ctl(codes[(i + 3) % 7])},
            {10'h0, b_ctl});
      check("mode A data", (codes[i] < 3'h5) ? 16'hf800 : 16'h0,
            a_data);
      reg_rd(UOR_OFS_STATUS, {5'h00, (codes[i] == 3'h7) ||
             (codes[(i + 3) % 7] == 3'h7), 2'b01});
    end
    reg_wr(UOR_OFS_RUN, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check("halt valid", 16'h0, {15'h0, cvalid});
    check("halt data B", 16'h0, b_data);
    check("halt ctl A", 16'h0, {10'h0, a_ctl});
    reg_rd(UOR_OFS_RUN, 8'h00);
    finish_test();
  end
endmodule : testbench
